//--- verilog/smsr_bank.sv
// Mode control and system status register bank with event interrupt.
//
// Operation
// - Bit 4 selects receive pin A or B
// - Receive select resets to pin A
// - Async mode routes pin A to frame sync
// - Async mode drives ROM pin from flag one
// - Async clear means plain synchronous wiring
// - Bit 6 selects single or double update
// - Bit 8 selects offset or independent aux
// - Status bit 0 shows shutdown pin level
// - Status bit 2 shows polarity pin level
// - Watchdog flag survives the watchdog reset
// - Status bit 3 shows PWM half cycle
`timescale 1ns/1ps
`include "smsr_regs.svh"

module smsr_bank
  import smsr_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           por_rst,
  input  wire smsr_bus_req_t  bus_req,
  output logic [15:0]         rdata,
  input  wire smsr_pins_t     pins,
  input  wire logic           serial_tx_frame_sync,
  input  wire logic           core_output_flag_one,
  input  wire logic           watchdog_timeout,
  input  wire logic           pwm_timer_counting_up,
  output smsr_mode_out_t      mode_out,
  output logic                irq
);

  logic [8:0]               mode_control_word_reg;
  logic                     wdog_flag_reg;
  smsr_pins_t               pins_meta_reg;
  smsr_pins_t               pins_sync_reg;
  logic [`SMSR_EV_W-1:0]    irq_stat_reg;
  logic [`SMSR_EV_W-1:0]    irq_mask_reg;
  logic [`SMSR_EV_W-1:0]    ev_now;
  logic                     trip_prev_reg;
  logic                     half_prev_reg;
  logic                     edge_armed_reg;
  logic [3:0]               system_status_word;
  logic [15:0]              rdata_next;
  smsr_mode_out_t           mode_out_next;
  logic                     rx_data_reg;
  logic                     rx_frame_sync_reg;
  logic                     rom_reset_o_reg;
  logic                     rom_reset_oe_reg;
  logic                     double_update_reg;
  logic                     aux_independent_reg;

  // Address compare shared by every decode below.
  function automatic logic hit(input logic [13:0] a, input logic [13:0] o);
    hit = (a == o);
  endfunction

  // A write lands only with the strobe high on the matching address.
  function automatic logic wr_hit(input smsr_bus_req_t r,
                                  input logic [13:0]   o);
    wr_hit = r.wr && hit(r.addr, o);
  endfunction

  // Read data for one address; unmapped and reserved bits read zero.
  function automatic logic [15:0] read_word(
    input logic [13:0]           a,
    input logic [8:0]            mode,
    input logic [3:0]            stat,
    input logic [`SMSR_EV_W-1:0] ev_stat,
    input logic [`SMSR_EV_W-1:0] ev_mask
  );
    read_word = 16'h0000;
    if (hit(a, `SMSR_MODE_OFFSET))
      read_word = {7'h00, mode};
    else if (hit(a, `SMSR_STAT_OFFSET))
      read_word = {12'h000, stat};
    else if (hit(a, `SMSR_IRQ_STAT_OFFSET))
      read_word = {13'h0000, ev_stat};
    else if (hit(a, `SMSR_IRQ_MASK_OFFSET))
      read_word = {13'h0000, ev_mask};
  endfunction

  // Pins come from outside the clock domain, so two flops before any use.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pins_meta_reg <= '0;
    else
      pins_meta_reg <= pins;
  end

  // Second stage: the only reader of the first stage.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pins_sync_reg <= '0;
    else
      pins_sync_reg <= pins_meta_reg;
  end

  // Unused bits are masked on the way in, so they always read back zero.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mode_control_word_reg <= `SMSR_MODE_RESET;
    else if (wr_hit(bus_req, `SMSR_MODE_OFFSET))
      mode_control_word_reg <= bus_req.wdata[8:0] & `SMSR_MODE_MASK;
  end

  // Only power-on reset clears the watchdog flag, so software can tell
  // a watchdog-caused reset from a normal start.
  always_ff @(posedge ref_clk or posedge por_rst)
  begin
    if (por_rst)
      wdog_flag_reg <= 1'b0;
    else if (watchdog_timeout)
      wdog_flag_reg <= 1'b1;
  end

  // Shutdown and polarity come through the synchroniser; the timer phase
  // and the watchdog flag are on-chip and need none.
  always_comb
  begin
    system_status_word = 4'h0;
    system_status_word[`SMSR_ST_TRIP_BIT] = pins_sync_reg.pwm_shutdown;
    system_status_word[`SMSR_ST_WDOG_BIT] = wdog_flag_reg;
    system_status_word[`SMSR_ST_POL_BIT] = pins_sync_reg.pwm_polarity;
    system_status_word[`SMSR_ST_HALF_BIT] = pwm_timer_counting_up;
  end

  // Previous levels for the two rising-edge event detectors.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      trip_prev_reg <= 1'b0;
    else
      trip_prev_reg <= pins_sync_reg.pwm_shutdown;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      half_prev_reg <= 1'b0;
    else
      half_prev_reg <= pwm_timer_counting_up;
  end

  // The detectors hold off for one cycle after reset, so a timer phase
  // already high at release is not taken for a new half cycle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      edge_armed_reg <= 1'b0;
    else
      edge_armed_reg <= 1'b1;
  end

  always_comb
  begin
    ev_now = '0;
    ev_now[`SMSR_EV_TRIP_BIT] = pins_sync_reg.pwm_shutdown & ~trip_prev_reg
                                & edge_armed_reg;
    ev_now[`SMSR_EV_WDOG_BIT] = watchdog_timeout;
    ev_now[`SMSR_EV_HALF_BIT] = pwm_timer_counting_up & ~half_prev_reg
                                & edge_armed_reg;
  end

  // A set in the same cycle as a write-one clear wins, so no event is lost.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_stat_reg <= '0;
    else if (wr_hit(bus_req, `SMSR_IRQ_STAT_OFFSET))
      irq_stat_reg <= (irq_stat_reg & ~bus_req.wdata[`SMSR_EV_W-1:0])
                      | ev_now;
    else
      irq_stat_reg <= irq_stat_reg | ev_now;
  end

  // The mask resets to zero so no interrupt fires before software asks.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_mask_reg <= '0;
    else if (wr_hit(bus_req, `SMSR_IRQ_MASK_OFFSET))
      irq_mask_reg <= bus_req.wdata[`SMSR_EV_W-1:0];
  end

  // Registered so the level never glitches while status and mask settle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  always_comb
  begin
    if (bus_req.rd)
      rdata_next = read_word(bus_req.addr, mode_control_word_reg,
                             system_status_word, irq_stat_reg,
                             irq_mask_reg);
    else
      rdata_next = 16'h0000;
  end

  // Read data stand for one cycle only and fall back to zero after it.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else
      rdata <= rdata_next;
  end

  // The reroute costs one register stage on every pin path; software
  // changes the mode rarely, so the added latency is harmless.
  always_comb
  begin
    mode_out_next.serial_rx_data =
      mode_control_word_reg[`SMSR_RX_SEL_BIT] ? pins_sync_reg.rx_pin_b
                                              : pins_sync_reg.rx_pin_a;
    if (mode_control_word_reg[`SMSR_ASYNC_BIT])
    begin
      mode_out_next.serial_rx_frame_sync = pins_sync_reg.rx_pin_a;
      mode_out_next.rom_reset_o = core_output_flag_one;
      mode_out_next.rom_reset_oe = 1'b1;
    end
    else
    begin
      // Synchronous mode: the frame sync pin keeps its own role.
      mode_out_next.serial_rx_frame_sync = 1'b0;
      mode_out_next.rom_reset_o = serial_tx_frame_sync;
      mode_out_next.rom_reset_oe = 1'b0;
    end
    mode_out_next.double_update =
      mode_control_word_reg[`SMSR_DOUBLE_UPD_BIT];
    mode_out_next.aux_independent =
      mode_control_word_reg[`SMSR_AUX_INDEP_BIT];
  end

  // One flop per routed output, so each path can be timed on its own and
  // every output leaves the block straight from a register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rx_data_reg <= 1'b0;
    else
      rx_data_reg <= mode_out_next.serial_rx_data;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rx_frame_sync_reg <= 1'b0;
    else
      rx_frame_sync_reg <= mode_out_next.serial_rx_frame_sync;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rom_reset_o_reg <= 1'b0;
    else
      rom_reset_o_reg <= mode_out_next.rom_reset_o;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rom_reset_oe_reg <= 1'b0;
    else
      rom_reset_oe_reg <= mode_out_next.rom_reset_oe;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      double_update_reg <= 1'b0;
    else
      double_update_reg <= mode_out_next.double_update;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      aux_independent_reg <= 1'b0;
    else
      aux_independent_reg <= mode_out_next.aux_independent;
  end

  // The output word is only wiring of the field flops above.
  assign mode_out = '{serial_rx_data:       rx_data_reg,
                      serial_rx_frame_sync: rx_frame_sync_reg,
                      rom_reset_o:          rom_reset_o_reg,
                      rom_reset_oe:         rom_reset_oe_reg,
                      double_update:        double_update_reg,
                      aux_independent:      aux_independent_reg};

endmodule

//--- verilog/smsr_regs.svh
// Register offsets, field positions and reset values of the mode/status bank.
`ifndef SMSR_REGS_SVH
`define SMSR_REGS_SVH

`define SMSR_ADDR_W          14
`define SMSR_DATA_W          16
`define SMSR_MODE_OFFSET     14'h2015
`define SMSR_STAT_OFFSET     14'h2016
`define SMSR_IRQ_STAT_OFFSET 14'h2017
`define SMSR_IRQ_MASK_OFFSET 14'h2019
`define SMSR_MODE_RESET      9'h000
`define SMSR_MODE_MASK       9'h170
`define SMSR_RX_SEL_BIT      4
`define SMSR_ASYNC_BIT       5
`define SMSR_DOUBLE_UPD_BIT  6
`define SMSR_AUX_INDEP_BIT   8
`define SMSR_ST_TRIP_BIT     0
`define SMSR_ST_WDOG_BIT     1
`define SMSR_ST_POL_BIT      2
`define SMSR_ST_HALF_BIT     3
`define SMSR_EV_W            3
`define SMSR_EV_TRIP_BIT     0
`define SMSR_EV_WDOG_BIT     1
`define SMSR_EV_HALF_BIT     2

`endif

//--- verilog/smsr_pkg.sv
// Types shared by the mode/status register bank.
package smsr_pkg;
  typedef struct packed
  {
    logic [13:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } smsr_bus_req_t;

  typedef struct packed
  {
    logic rx_pin_a;
    logic rx_pin_b;
    logic pwm_shutdown;
    logic pwm_polarity;
  } smsr_pins_t;

  typedef struct packed
  {
    logic serial_rx_data;
    logic serial_rx_frame_sync;
    logic rom_reset_o;
    logic rom_reset_oe;
    logic double_update;
    logic aux_independent;
  } smsr_mode_out_t;
endpackage

//--- dv/smsr_rom_model.sv
// Serial boot memory model that answers on receive pin A.
`timescale 1ns/1ps
module smsr_rom_model
(
  input  wire logic ref_clk,
  input  wire logic rom_rst,
  output logic      dout
);
  // Out of reset the memory streams bits, so the line never rests.
  initial dout = 1'b0;
  always @(posedge ref_clk) dout <= rom_rst ? 1'b1 : ~dout;
endmodule

//--- dv/smsr_checker.sv
// Assertion checker bound to the mode/status register bank.
`timescale 1ns/1ps
`include "smsr_regs.svh"
module smsr_checker
  import smsr_pkg::*;
(
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic           por_rst,
  input wire smsr_bus_req_t  bus_req,
  input wire logic [15:0]    rdata,
  input wire smsr_pins_t     pins,
  input wire logic           serial_tx_frame_sync,
  input wire logic           core_output_flag_one,
  input wire logic           watchdog_timeout,
  input wire logic           pwm_timer_counting_up,
  input wire smsr_mode_out_t mode_out,
  input wire logic           irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rm = bus_req.rd && bus_req.addr == `SMSR_MODE_OFFSET;
  wire rs = bus_req.rd && bus_req.addr == `SMSR_STAT_OFFSET;
  wire wm = bus_req.wr && bus_req.addr == `SMSR_MODE_OFFSET;
  wire up = pwm_timer_counting_up;
  wire wd = watchdog_timeout;
  wire oe = mode_out.rom_reset_oe;
  a_rd_idle: assert property (!$past(bus_req.rd) |-> rdata == 16'h0)
    else $error("rdata outside read");
  a_mode_rsv: assert property ($past(rm) |-> !(rdata & 16'hfe8f))
    else $error("mode unused bits");
  a_stat_rsv: assert property ($past(rs) |-> rdata[15:4] == 12'h0)
    else $error("status unused bits");
  a_wdog_seen: assert property ($past(rs) && $past(wd, 2) |-> rdata[1])
    else $error("watchdog flag");
  a_half_cyc: assert property ($past(rs) && $past(up) == $past(up, 2)
    |-> rdata[3] == $past(up)) else $error("half cycle bit");
  a_rom_flag: assert property (oe
    |-> mode_out.rom_reset_o == $past(core_output_flag_one))
    else $error("rom pin");
  a_fs_sync: assert property (!oe |-> !mode_out.serial_rx_frame_sync)
    else $error("frame sync");
  a_dbl_upd: assert property (wm
    |-> ##2 mode_out.double_update == $past(bus_req.wdata[6], 2))
    else $error("update mode");
  c_irq: cover property (irq);
  c_oe: cover property (oe);
  c_wdog: cover property ($past(rs) && rdata[1]);
endmodule
bind smsr_bank smsr_checker chk (.*);

//--- dv/smsr_bank_bench.sv
// Self-checking bench for the mode/status register bank.
`timescale 1ns/1ps
`include "smsr_regs.svh"
module smsr_bank_bench;
  import smsr_pkg::*;
  localparam logic [13:0] ad_m = `SMSR_MODE_OFFSET, ad_s = `SMSR_STAT_OFFSET;
  localparam logic [13:0] ad_is = `SMSR_IRQ_STAT_OFFSET;
  localparam logic [13:0] ad_im = `SMSR_IRQ_MASK_OFFSET;
  logic ref_clk = 0, rst = 1, por_rst = 1, rd_d = 0, rom_q, irq;
  logic rxb = 0, shut = 0, pol = 0;
  logic serial_tx_frame_sync = 0, core_output_flag_one = 1;
  logic watchdog_timeout = 0, pwm_timer_counting_up = 0;
  logic [15:0] rdata, v, q[$];
  int error_cnt = 0, n_tests = 0;
  smsr_bus_req_t bus_req = '0;
  smsr_mode_out_t mode_out;
  smsr_pins_t pins;
  assign pins = {rom_q, rxb, shut, pol};
  always #2 ref_clk = ~ref_clk;
  smsr_bank uut (.*);
  smsr_rom_model rom (.ref_clk(ref_clk), .dout(rom_q),
    .rom_rst(mode_out.rom_reset_oe && mode_out.rom_reset_o));
  function logic [15:0] st(input logic w);
    return {12'h0, pwm_timer_counting_up, pol, w, shut};
  endfunction
  task chk(input logic [15:0] s, e, input string n);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task op(input logic w, r, input logic [13:0] a, input logic [15:0] d);
    bus_req <= '{a, d, w, r};
    @(posedge ref_clk);
  endtask
  task rd(input logic [13:0] a, input logic [15:0] e);
    q.push_back(e);
    op(0, 1, a, 0);
  endtask
  task idle(input int n);
    bus_req <= '0;
    repeat (n) @(posedge ref_clk);
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    if (rd_d) chk(rdata, q.pop_front(), "rdata");
    rd_d <= bus_req.rd;
  end
  initial
  begin
    #20000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(47));
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    por_rst <= 0;
    @(posedge ref_clk);
    rd(ad_m, 16'h0);
    op(1, 0, 14'h2018, 16'hffff);
    rd(14'h2018, 16'h0);
    repeat (12)
    begin
      v = 16'($urandom);
      {rxb, shut, pol, pwm_timer_counting_up, serial_tx_frame_sync} <= v[15:11];
      op(1, 0, ad_m, v);
      rd(ad_m, v & 16'h0170);
      idle(5);
      rd(ad_s, st(0));
      idle(1);
      chk(mode_out.double_update, v[6], "dbl");
      chk(mode_out.aux_independent, v[8], "aux");
      chk(mode_out.rom_reset_oe, v[5], "oe");
      chk(mode_out.rom_reset_o, v[5] | serial_tx_frame_sync, "rom");
      chk(mode_out.serial_rx_frame_sync, v[5], "fs");
      if (v[4] | v[5]) chk(mode_out.serial_rx_data, v[4] ? rxb : 1, "rx");
    end
    op(1, 0, ad_m, 16'h0020);
    core_output_flag_one <= 0;
    idle(4);
    chk(mode_out.rom_reset_o, 0, "rom");
    core_output_flag_one <= 1;
    idle(2);
    chk(mode_out.rom_reset_o, 1, "rom");
    op(1, 0, ad_is, 16'h0007);
    op(1, 0, ad_im, 16'h0002);
    watchdog_timeout <= 1;
    idle(1);
    watchdog_timeout <= 0;
    idle(2);
    chk(irq, 1, "irq");
    rd(ad_is, 16'h0002);
    op(1, 0, ad_im, 16'h0);
    idle(3);
    chk(irq, 0, "irq");
    op(1, 0, ad_is, 16'h0002);
    op(1, 0, ad_im, 16'h0002);
    idle(3);
    chk(irq, 0, "irq");
    rst <= 1;
    idle(2);
    rst <= 0;
    idle(4);
    rd(ad_s, st(1));
    rd(ad_m, 16'h0);
    por_rst <= 1;
    idle(1);
    por_rst <= 0;
    rd(ad_s, st(0));
    idle(2);
    give_verdict;
  end
endmodule
